// >>> shared/acr_map.vh
// Constants for the audio rate control block
`ifndef ACR_MAP_VH
`define ACR_MAP_VH
`define ACR_OFF_CTRL      12'h000
`define ACR_OFF_DIV       12'h004
`define ACR_OFF_ATTEN     12'h008
`define ACR_OFF_GPIO_DIR  12'h00C
`define ACR_OFF_GPIO_OUT  12'h010
`define ACR_OFF_GPIO_IN   12'h014
`define ACR_OFF_STATUS    12'h018
`define ACR_OFF_TX        12'h01C
`define ACR_OFF_RX        12'h020
`define ACR_CTRL_OFFC_DIS 13
`define ACR_CTRL_MUTE     0
`define ACR_CTRL_LOOP     1
`define ACR_CTRL_ENA      2
`define ACR_DIV_MIN       7'd8
`define ACR_DIV_MAX       7'd127
`define ACR_DIV_RST       7'h0C
`define ACR_OSR           64
`define ACR_HALF_PER_DIV  32
`define ACR_ATTEN_RST     5'h00
`define ACR_ATTEN_MAX     5'h17
`define ACR_CTRL_RST      32'h00000000
`define ACR_RUN_EDGES     8'h10
`endif

// >>> core/acr_fifo.v
// Sample FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module acr_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             mclk,
	input  wire             reset_n,
	input  wire [WIDTH-1:0] in_data,
	input  wire             in_valid,
	output wire             in_ready,
	output wire [WIDTH-1:0] out_data,
	output wire             out_valid,
	input  wire             out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0]      wp_r;
	reg [AW:0]      rp_r;
	wire            full;
	wire            empty;
	assign full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
	assign empty = (wp_r == rp_r);
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem[rp_r[AW-1:0]];
	always @(posedge mclk) begin
		if (in_valid && !full)
			mem[wp_r[AW-1:0]] <= in_data;
	end
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			wp_r <= {(AW+1){1'b0}};
			rp_r <= {(AW+1){1'b0}};
		end else begin
			if (in_valid && !full)
				wp_r <= wp_r + 1'b1;
			if (out_ready && !empty)
				rp_r <= rp_r + 1'b1;
		end
	end
endmodule
`default_nettype wire

// >>> core/acr_top.v
// Audio sample rate control with APB registers and serial bus data out
//
// Behaviour
// - Sample rate = 2*fclk/(64*div), div 8..127
// - Odd divisor counts both serial clock edges
// - Input path oversamples 64x, decimates per sample
// - Output path interpolates into 4-bit 64x converter
// - Control bit 13 disables offset cancellation
// - Output attenuation and mute are programmable
// - Loopback feeds output path into input path
// - Serial bus carries samples only; registers go over APB
// - Serial data out held 1 until bus runs
// - General pins are inputs after reset
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "acr_map.vh"
module acr_top #(
	parameter NGPIO = 10,
	parameter SW    = 16
) (
	input  wire             mclk,
	input  wire             reset_n,
	input  wire             psel,
	input  wire             penable,
	input  wire             pwrite,
	input  wire [11:0]      paddr,
	input  wire [31:0]      pwdata,
	output reg  [31:0]      prdata,
	output reg              pready,
	output reg              pslverr,
	input  wire             serial_bus_clock,
	input  wire             serial_data_in,
	input  wire [NGPIO-1:0] general_pin_i,
	output reg  [NGPIO-1:0] general_pin_o,
	output reg  [NGPIO-1:0] general_pin_oe,
	output reg              serial_data_out,
	output reg              sample_strobe,
	output reg              os_strobe,
	output reg  [3:0]       dac_code,
	output reg              offset_cancel_en,
	output reg              spk_mute,
	output reg  [4:0]       spk_atten,
	output reg              loopback_en
);
	reg [31:0]      ctrl_r;
	reg [6:0]       div_r;
	reg [4:0]       atten_r;
	reg [NGPIO-1:0] gdir_r;
	reg [NGPIO-1:0] gout_r;
	reg [1:0]       ck_sync_r;
	reg [1:0]       din_sync_r;
	reg [NGPIO-1:0] g_s1_r;
	reg [NGPIO-1:0] g_s2_r;
	reg             ck_prev_r;
	reg [12:0]      edge_cnt_r;
	reg [6:0]       os_edge_r;
	reg [7:0]       run_cnt_r;
	reg             running_r;
	reg [SW-1:0]    tx_shift_r;
	reg [SW-1:0]    rx_shift_r;
	reg [4:0]       bit_cnt_r;
	reg [SW-1:0]    rx_word_r;
	reg             rx_new_r;
	reg [SW-1:0]    cur_out_r;
	reg [SW+3:0]    interp_r;
	reg [SW+5:0]    decim_acc_r;
	reg [SW-1:0]    adc_word_r;
	reg             div_err_r;
	wire            ck_rise;
	wire            ck_fall;
	wire            ck_edge;
	wire [12:0]     edge_target;
	wire            wr;
	wire            rd;
	wire            tx_ready;
	wire [SW-1:0]   tx_data;
	wire            tx_valid;
	wire            fifo_out_ready;
	wire [6:0]      os_target;
	wire            word_done;

	function addr_ok;
		input [11:0] a;
		begin
			addr_ok = (a == `ACR_OFF_CTRL) || (a == `ACR_OFF_DIV) ||
				(a == `ACR_OFF_ATTEN) || (a == `ACR_OFF_GPIO_DIR) ||
				(a == `ACR_OFF_GPIO_OUT) || (a == `ACR_OFF_GPIO_IN) ||
				(a == `ACR_OFF_STATUS) || (a == `ACR_OFF_TX) ||
				(a == `ACR_OFF_RX);
		end
	endfunction

	assign wr = psel && penable && pwrite && pready;
	assign rd = psel && !penable && !pwrite;
	assign ck_rise = ck_sync_r[1] && !ck_prev_r;
	assign ck_fall = !ck_sync_r[1] && ck_prev_r;
	// Odd divisors need half-period resolution, so both edges count
	assign ck_edge = div_r[0] ? (ck_rise || ck_fall) : ck_rise;
	// One sample is div*32 link periods: div*64 edges, or div*32 rises
	assign edge_target = div_r[0] ? {div_r, 6'h00} :
		{1'b0, div_r, 5'h00};
	// Oversample tick every target/64 counted edges
	assign os_target = div_r[0] ? div_r : {1'b0, div_r[6:1]};
	assign word_done = ck_rise && running_r && (bit_cnt_r == SW - 1);
	// Empty FIFO keeps the last sample, so an underrun repeats it
	assign fifo_out_ready = sample_strobe;

	acr_fifo #(.WIDTH(SW), .DEPTH(16), .AW(4)) acr_fifo_i (
		.mclk      (mclk),
		.reset_n   (reset_n),
		.in_data   (pwdata[SW-1:0]),
		.in_valid  (wr && (paddr == `ACR_OFF_TX)),
		.in_ready  (tx_ready),
		.out_data  (tx_data),
		.out_valid (tx_valid),
		.out_ready (fifo_out_ready)
	);

	// Pin inputs pass two flops before use
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ck_sync_r  <= 2'b00;
			din_sync_r <= 2'b00;
			ck_prev_r  <= 1'b0;
		end else begin
			ck_sync_r  <= {ck_sync_r[0], serial_bus_clock};
			din_sync_r <= {din_sync_r[0], serial_data_in};
			ck_prev_r  <= ck_sync_r[1];
		end
	end

	// Each general pin gets its own two-flop synchroniser
	genvar gi;
	generate
		for (gi = 0; gi < NGPIO; gi = gi + 1) begin : g_pin_sync
			always @(posedge mclk or negedge reset_n) begin
				if (!reset_n) begin
					g_s1_r[gi] <= 1'b0;
					g_s2_r[gi] <= 1'b0;
				end else begin
					g_s1_r[gi] <= general_pin_i[gi];
					g_s2_r[gi] <= g_s1_r[gi];
				end
			end
		end
	endgenerate

	// APB slave, no wait states; pready high in access phase
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_r    <= `ACR_CTRL_RST;
			div_r     <= `ACR_DIV_RST;
			atten_r   <= `ACR_ATTEN_RST;
			gdir_r    <= {NGPIO{1'b0}};
			gout_r    <= {NGPIO{1'b0}};
			prdata    <= 32'h00000000;
			pready    <= 1'b0;
			pslverr   <= 1'b0;
			div_err_r <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !addr_ok(paddr);
			if (rd) begin
				case (paddr)
				`ACR_OFF_CTRL:     prdata <= ctrl_r;
				`ACR_OFF_DIV:      prdata <= {25'h0, div_r};
				`ACR_OFF_ATTEN:    prdata <= {27'h0, atten_r};
				`ACR_OFF_GPIO_DIR: prdata <= {{(32-NGPIO){1'b0}}, gdir_r};
				`ACR_OFF_GPIO_OUT: prdata <= {{(32-NGPIO){1'b0}}, gout_r};
				`ACR_OFF_GPIO_IN:  prdata <= {{(32-NGPIO){1'b0}}, g_s2_r};
				`ACR_OFF_STATUS:   prdata <= {28'h0, div_err_r, !tx_ready,
					running_r, rx_new_r};
				`ACR_OFF_RX:       prdata <= {{(32-SW){1'b0}}, adc_word_r};
				default:           prdata <= 32'h00000000;
				endcase
			end
			if (wr) begin
				case (paddr)
				`ACR_OFF_CTRL: ctrl_r <= pwdata;
				`ACR_OFF_DIV: begin
					// Out-of-range divisor refused and flagged
					if (pwdata[6:0] >= `ACR_DIV_MIN) begin
						div_r     <= pwdata[6:0];
						div_err_r <= 1'b0;
					end else
						div_err_r <= 1'b1;
				end
				`ACR_OFF_ATTEN: begin
					if (pwdata[4:0] <= `ACR_ATTEN_MAX)
						atten_r <= pwdata[4:0];
				end
				`ACR_OFF_GPIO_DIR: gdir_r <= pwdata[NGPIO-1:0];
				`ACR_OFF_GPIO_OUT: gout_r <= pwdata[NGPIO-1:0];
				default: ;
				endcase
			end
		end
	end

	// Sample timing, oversampling, serial data path
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			edge_cnt_r       <= 13'h0000;
			os_edge_r        <= 7'h00;
			sample_strobe    <= 1'b0;
			os_strobe        <= 1'b0;
			run_cnt_r        <= 8'h00;
			running_r        <= 1'b0;
			serial_data_out  <= 1'b1;
			tx_shift_r       <= {SW{1'b0}};
			rx_shift_r       <= {SW{1'b0}};
			bit_cnt_r        <= 5'h00;
			rx_word_r        <= {SW{1'b0}};
			rx_new_r         <= 1'b0;
			cur_out_r        <= {SW{1'b0}};
			interp_r         <= {(SW+4){1'b0}};
			decim_acc_r      <= {(SW+6){1'b0}};
			adc_word_r       <= {SW{1'b0}};
			dac_code         <= 4'h0;
			offset_cancel_en <= 1'b1;
			spk_mute         <= 1'b0;
			spk_atten        <= `ACR_ATTEN_RST;
			loopback_en      <= 1'b0;
			general_pin_o    <= {NGPIO{1'b0}};
			general_pin_oe   <= {NGPIO{1'b0}};
		end else begin
			offset_cancel_en <= !ctrl_r[`ACR_CTRL_OFFC_DIS];
			spk_mute         <= ctrl_r[`ACR_CTRL_MUTE];
			spk_atten        <= atten_r;
			loopback_en      <= ctrl_r[`ACR_CTRL_LOOP];
			general_pin_o    <= gout_r;
			general_pin_oe   <= gdir_r;
			sample_strobe    <= 1'b0;
			os_strobe        <= 1'b0;
			// Data out stays high until the link has clocked a while
			if (ck_rise && !running_r) begin
				if (run_cnt_r == `ACR_RUN_EDGES - 8'h01)
					running_r <= 1'b1;
				run_cnt_r <= run_cnt_r + 8'h01;
			end
			if (ck_edge && running_r) begin
				if (edge_cnt_r >= edge_target - 13'h0001) begin
					edge_cnt_r    <= 13'h0000;
					sample_strobe <= 1'b1;
					// Realign ticks to the frame after a divisor change
					os_edge_r     <= 7'h00;
					os_strobe     <= 1'b1;
				end else begin
					edge_cnt_r <= edge_cnt_r + 13'h0001;
					if (os_edge_r >= os_target - 7'h01) begin
						os_edge_r <= 7'h00;
						os_strobe <= 1'b1;
					end else
						os_edge_r <= os_edge_r + 7'h01;
				end
			end
			// Serial exchange: shift out on rise, sample in on rise
			if (ck_rise && running_r) begin
				serial_data_out <= tx_shift_r[SW-1];
				tx_shift_r <= {tx_shift_r[SW-2:0], 1'b0};
				rx_shift_r <= {rx_shift_r[SW-2:0], din_sync_r[1]};
				if (bit_cnt_r == SW - 1) begin
					bit_cnt_r <= 5'h00;
					rx_word_r <= {rx_shift_r[SW-2:0], din_sync_r[1]};
					rx_new_r  <= 1'b1;
				end else
					bit_cnt_r <= bit_cnt_r + 5'h01;
			end
			if (sample_strobe) begin
				// Frame starts: next output sample taken from FIFO
				cur_out_r  <= tx_valid ? tx_data : cur_out_r;
				tx_shift_r <= adc_word_r;
				// Decimated value: one word per sample period
				adc_word_r <= decim_acc_r[SW+5:6];
				// A word completing now keeps its flag: set wins
				if (!word_done)
					rx_new_r <= 1'b0;
			end
			if (os_strobe) begin
				// Interpolate toward current output sample
				interp_r <= interp_r - {4'h0, interp_r[SW+3:4]} +
					{4'h0, cur_out_r};
				// First tick of a frame restarts the sum of 64
				decim_acc_r <= (sample_strobe ?
					{(SW+6){1'b0}} : decim_acc_r) +
					(loopback_en ? {6'h00, cur_out_r} :
					{6'h00, rx_word_r});
			end
			// Mute forces midscale at once, not at the next tick
			if (spk_mute)
				dac_code <= 4'h8;
			else if (os_strobe)
				dac_code <= interp_r[SW+3:SW];
		end
	end
endmodule
`default_nettype wire

// >>> verification/acr_sva.sv
// Port assertions for the audio rate control top
`timescale 1ns/1ps
`default_nettype none
module acr_sva #(
	parameter NGPIO = 10
) (
	input wire logic             mclk,
	input wire logic             reset_n,
	input wire logic             psel,
	input wire logic             penable,
	input wire logic             pwrite,
	input wire logic [11:0]      paddr,
	input wire logic [31:0]      pwdata,
	input wire logic             pready,
	input wire logic             pslverr,
	input wire logic             serial_bus_clock,
	input wire logic [NGPIO-1:0] general_pin_oe,
	input wire logic             serial_data_out,
	input wire logic [3:0]       dac_code,
	input wire logic             offset_cancel_en,
	input wire logic             spk_mute,
	input wire logic             loopback_en
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	logic [4:0] edges_r;
	logic       sbc_q_r;
	wire        ctrl_wr = psel && penable && pready && pwrite && paddr == 12'h000;
	// Raw edge count runs ahead of the synchroniser, so the bound is safe
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			edges_r <= 5'h00;
			sbc_q_r <= 1'b0;
		end else begin
			sbc_q_r <= serial_bus_clock;
			if (serial_bus_clock && !sbc_q_r && edges_r != 5'h1F)
				edges_r <= edges_r + 5'h01;
		end
	end
	a_ready_in_access: assert property (pready |-> psel && penable)
		else $error("pready outside access");
	a_setup_answered: assert property (psel && !penable |=> pready)
		else $error("no pready after setup");
	a_offset_off: assert property (
		ctrl_wr && pwdata[13] |=> ##1 !offset_cancel_en)
		else $error("cancel not off");
	a_offset_on: assert property (
		ctrl_wr && !pwdata[13] |=> ##1 offset_cancel_en)
		else $error("cancel not on");
	a_loop_follows: assert property (
		ctrl_wr |=> ##1 loopback_en == $past(pwdata[1], 2))
		else $error("loopback wrong");
	a_mute_midscale: assert property (
		spk_mute && $past(spk_mute) |-> dac_code == 4'h8)
		else $error("mute not midscale");
	a_reset_state: assert property (
		!$past(reset_n) |-> general_pin_oe == '0 && serial_data_out)
		else $error("bad state after reset");
	a_dout_held: assert property (edges_r < 5'h10 |-> serial_data_out)
		else $error("data out early");
	c_ctrl_write: cover property (ctrl_wr);
	c_slv_error: cover property (pslverr);
	c_dout_low: cover property (!serial_data_out);
endmodule
`default_nettype wire

// >>> verification/acr_link_model.sv
// Controller side of the serial link: clock and data in
`timescale 1ns/1ps
`default_nettype none
module acr_link_model (
	input  wire logic run,
	output var  logic serial_bus_clock,
	output var  logic serial_data_in
);
	logic [15:0] pat_r;
	initial begin
		serial_bus_clock = 1'b0;
		serial_data_in = 1'b1;
		pat_r = 16'hA5C3;
		// Phase offset keeps link edges off the system clock edges
		#7;
		forever begin
			#80;
			if (run || serial_bus_clock)
				serial_bus_clock = ~serial_bus_clock;
		end
	end
	always @(negedge serial_bus_clock) begin
		serial_data_in <= pat_r[15];
		pat_r <= {pat_r[14:0], pat_r[15]};
	end
endmodule
`default_nettype wire

// >>> verification/test_audio_codec_rate_control.sv
// Register, link and rate tests for the audio rate control block
`timescale 1ns/1ps
`default_nettype none
`include "acr_map.vh"
module test_audio_codec_rate_control;
	localparam NGPIO = 10;
	logic             mclk, reset_n, psel, penable, pwrite, pready, pslverr;
	logic [11:0]      paddr;
	logic [31:0]      pwdata, prdata, rdat;
	logic [NGPIO-1:0] general_pin_i, general_pin_o, general_pin_oe;
	logic             serial_bus_clock, serial_data_in, serial_data_out;
	logic             sample_strobe, os_strobe, offset_cancel_en, spk_mute;
	logic             loopback_en, rerr, run;
	logic [3:0]       dac_code;
	logic [4:0]       spk_atten;
	int               num_errors, tests_run, n, m;
	acr_top acr_top_i (.mclk, .reset_n, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .serial_bus_clock,
		.serial_data_in, .general_pin_i, .general_pin_o, .general_pin_oe,
		.serial_data_out, .sample_strobe, .os_strobe, .dac_code,
		.offset_cancel_en, .spk_mute, .spk_atten, .loopback_en);
	acr_link_model acr_link_model_i (.run, .serial_bus_clock, .serial_data_in);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
			input logic [31:0] d);
		int k;
		k = 0;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		chk(k < 50, 1'h1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge mclk);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdat, e);
	endtask
	// Cycles and oversample ticks from one sample strobe to the next
	task automatic gap(output int c, output int o);
		int k;
		k = 0;
		c = 1;
		o = 0;
		do @(posedge mclk); while (sample_strobe !== 1'b1 && ++k < 9000);
		do begin
			@(posedge mclk);
			o += (os_strobe === 1'b1);
		end while (sample_strobe !== 1'b1 && ++c < 9000);
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	initial begin
		#1000000;
		num_errors++;
		results;
	end
	initial begin
		reset_n = 1'b0;
		{psel, penable, pwrite, paddr, pwdata, run} = '0;
		general_pin_i = 10'h2A5;
		repeat (10) @(posedge mclk);
		reset_n <= 1'b1;
		rdc(`ACR_OFF_DIV, 32'hC);
		rdc(`ACR_OFF_CTRL, 32'h0);
		rdc(`ACR_OFF_GPIO_DIR, 32'h0);
		chk(general_pin_oe, 32'h0);
		chk(serial_data_out, 32'h1);
		chk(offset_cancel_en, 32'h1);
		apb(1'b0, 12'h0FC, 32'h0);
		chk(rerr, 32'h1);
		apb(1'b1, `ACR_OFF_GPIO_DIR, 32'h3FF);
		apb(1'b1, `ACR_OFF_GPIO_OUT, 32'h155);
		@(negedge mclk);
		chk(general_pin_oe, 32'h3FF);
		chk(general_pin_o, 32'h155);
		rdc(`ACR_OFF_GPIO_IN, 32'h2A5);
		$display("test reset and pins done");
		apb(1'b1, `ACR_OFF_DIV, 32'h7);
		rdc(`ACR_OFF_DIV, 32'hC);
		rdc(`ACR_OFF_DIV, 32'hC);
		apb(1'b0, `ACR_OFF_STATUS, 32'h0);
		chk(rdat[3], 32'h1);
		apb(1'b1, `ACR_OFF_DIV, 32'h7F);
		rdc(`ACR_OFF_DIV, 32'h7F);
		apb(1'b1, `ACR_OFF_DIV, 32'h8);
		rdc(`ACR_OFF_DIV, 32'h8);
		apb(1'b1, `ACR_OFF_CTRL, 32'h2003);
		repeat (2) @(negedge mclk);
		chk(offset_cancel_en, 32'h0);
		chk({spk_mute, dac_code}, 32'h18);
		chk(loopback_en, 32'h1);
		apb(1'b1, `ACR_OFF_CTRL, 32'h0);
		@(negedge mclk);
		chk({offset_cancel_en, loopback_en}, 32'h2);
		apb(1'b1, `ACR_OFF_ATTEN, 32'h17);
		apb(1'b1, `ACR_OFF_ATTEN, 32'h18);
		chk(spk_atten, 32'h17);
		$display("test registers done");
		for (int i = 0; i < 17; i++)
			apb(1'b1, `ACR_OFF_TX, 32'h100 + i);
		apb(1'b0, `ACR_OFF_STATUS, 32'h0);
		chk(rdat[2:1], 32'h2);
		chk(serial_data_out, 32'h1);
		// Sixteen link rising edges at eight system cycles each
		run <= 1'b1;
		repeat (150) @(posedge mclk);
		apb(1'b0, `ACR_OFF_STATUS, 32'h0);
		chk(rdat[1], 32'h1);
		gap(n, m);
		chk(n, 32'h800);
		chk(m, 32'h40);
		apb(1'b0, `ACR_OFF_STATUS, 32'h0);
		chk(rdat[2], 32'h0);
		apb(1'b1, `ACR_OFF_DIV, 32'h9);
		gap(n, m);
		repeat (2) begin
			gap(n, m);
			chk(n, 32'h900);
			chk(m, 32'h40);
		end
		$display("test link and rate done");
		results;
	end
endmodule
bind acr_top acr_sva #(.NGPIO(NGPIO)) acr_sva_i (.mclk, .reset_n, .psel,
	.penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
	.serial_bus_clock, .general_pin_oe, .serial_data_out, .dac_code,
	.offset_cancel_en, .spk_mute, .loopback_en);
`default_nettype wire
